// ==== common/startup_pkg.sv ====
// Constants, register map and state encoding for the start-up controller
package startup_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] PMC_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] RRC_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
  // power_management_control fields
  localparam int MULT_W = 7;
  localparam int MULT_LSB = 0;
  localparam int DIV_W = 2;
  localparam int DIV_LSB = 8;
  localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
  // running_reset_control fields
  localparam int RRC_INPUT_BIT = 0;
  // Status fields
  localparam int ST_RATIO_LSB = 0;
  localparam int ST_RSVD_BIT = 2;
  localparam int ST_BOOT_LSB = 3;
  localparam int ST_STATE_LSB = 6;
  localparam int ST_PINMODE_BIT = 8;
  localparam int ST_LOCKED_BIT = 9;
  // Clock ratio strap codes and resulting multipliers
  localparam int RATIO_W = 2;
  localparam logic [RATIO_W-1:0] RATIO_8 = 2'h0;
  localparam logic [RATIO_W-1:0] RATIO_32 = 2'h1;
  localparam logic [RATIO_W-1:0] RATIO_16 = 2'h2;
  localparam logic [RATIO_W-1:0] RATIO_RSVD = 2'h3;
  localparam logic [MULT_W-1:0] MULT_8 = 7'h08;
  localparam logic [MULT_W-1:0] MULT_16 = 7'h10;
  localparam logic [MULT_W-1:0] MULT_32 = 7'h20;
  // Boot configuration width
  localparam int BOOT_W = 3;
  // Lock latency in input clock cycles, and the cycle rate
  localparam int LOCK_LATENCY_INPUT_CLOCK = 4096;
  localparam int INPUT_CLOCK_PER_SYS_CLK = 1;
  localparam int LOCK_CYCLES_DEF = LOCK_LATENCY_INPUT_CLOCK * INPUT_CLOCK_PER_SYS_CLK;
  // Strap sampling point after release, past the synchroniser
  localparam int SYNC_STAGES = 2;
  localparam int CAPTURE_AT = SYNC_STAGES + 1;
  // Core reset vector
  localparam logic [31:0] RESET_VECTOR_DEF = 32'h0008_0000;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOCK = 2'b01,
    ST_RUN = 2'b10,
    ST_HOLD = 2'b11
  } seq_state_t;
endpackage

// ==== hdl/startup_ctrl.sv ====
// Start-up clock ratio, boot mode, lock wait and reset pin control
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module startup_ctrl #(
  parameter int LOCK_CYCLES = startup_pkg::LOCK_CYCLES_DEF,
  parameter logic [31:0] RESET_VECTOR = startup_pkg::RESET_VECTOR_DEF
) (
  // Clock and hardware reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Strap pins
  input wire logic [startup_pkg::RATIO_W-1:0] clk_ratio_i,
  input wire logic [startup_pkg::BOOT_W-1:0] boot_cfg_i,
  // Dual-function reset pin
  input wire logic running_reset_n_i,
  output logic reset_output_n_o,
  output logic reset_output_oe_o,
  // Register port
  input wire logic [startup_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [startup_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [startup_pkg::DATA_W-1:0] reg_rdata_o,
  // Core and PLL control
  output logic core_reset_o,
  output logic core_start_o,
  output logic [31:0] core_pc_o,
  output logic [startup_pkg::BOOT_W-1:0] boot_mode_o,
  output logic [startup_pkg::MULT_W-1:0] pll_mult_o,
  output logic [startup_pkg::DIV_W-1:0] pll_div_o
);
  import startup_pkg::*;

  localparam int CNT_W = $clog2(LOCK_CYCLES + 1);

  // Refuse counts the sequencer cannot serve
  generate
    if (LOCK_CYCLES <= CAPTURE_AT) begin : g_bad_lock
      $error("LOCK_CYCLES must exceed the strap capture point");
    end
    if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("Pin synchronisers are built with exactly two stages");
    end
  endgenerate

  seq_state_t state_q;
  seq_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [RATIO_W-1:0] ratio_s1_q;
  logic [RATIO_W-1:0] ratio_s2_q;
  logic [BOOT_W-1:0] boot_s1_q;
  logic [BOOT_W-1:0] boot_s2_q;
  logic rrst_s1_q;
  logic rrst_s2_q;
  logic [RATIO_W-1:0] ratio_q;
  logic rsvd_q;
  logic pin_input_q;
  logic locked_q;
  logic [1:0] settle_q;
  logic [MULT_W-1:0] strap_mult;
  logic lock_done;
  logic capture;
  logic rrst_active;
  logic [DATA_W-1:0] rd_d;

  // Ratio strap synchroniser
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ratio_s1_q <= '0;
      ratio_s2_q <= '0;
    end else begin
      ratio_s1_q <= clk_ratio_i;
      ratio_s2_q <= ratio_s1_q;
    end
  end

  // Boot strap synchroniser
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_s1_q <= '0;
      boot_s2_q <= '0;
    end else begin
      boot_s1_q <= boot_cfg_i;
      boot_s2_q <= boot_s1_q;
    end
  end

  // Running reset synchroniser; idles high like the pulled-up pin
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rrst_s1_q <= 1'b1;
      rrst_s2_q <= 1'b1;
    end else begin
      rrst_s1_q <= running_reset_n_i;
      rrst_s2_q <= rrst_s1_q;
    end
  end

  // Strap decode; a reserved code falls back to the slowest ratio
  always_comb begin
    unique case (ratio_s2_q)
      RATIO_8: strap_mult = MULT_8;
      RATIO_32: strap_mult = MULT_32;
      RATIO_16: strap_mult = MULT_16;
      default: strap_mult = MULT_8;
    endcase
  end

  // Sample only once the synchroniser holds real pin levels
  assign capture = (state_q == ST_LOCK) && (cnt_q == CNT_W'(CAPTURE_AT));
  assign lock_done = (state_q == ST_LOCK) && (cnt_q == CNT_W'(LOCK_CYCLES - 1));
  // Running reset only counts once the pin is an input and the
  // synchroniser no longer holds our own drive level
  assign rrst_active = pin_input_q && (settle_q == 2'(SYNC_STAGES)) && !rrst_s2_q;

  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: state_d = ST_LOCK;
      ST_LOCK: begin
        if (lock_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rrst_active) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!rrst_active) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  // State register; hardware reset forces a known start
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Lock latency counter, counted from release of reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (state_q == ST_RESET || state_q == ST_LOCK) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Lock flag, cleared only by hardware reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_q <= 1'b0;
    end else if (lock_done) begin
      locked_q <= 1'b1;
    end
  end

  // Ratio strap capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ratio_q <= RATIO_8;
      rsvd_q <= 1'b0;
    end else if (capture) begin
      ratio_q <= ratio_s2_q;
      rsvd_q <= (ratio_s2_q == RATIO_RSVD);
    end
  end

  // Boot mode, taken at power-up and again at each running reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_mode_o <= '0;
    end else if (capture || state_q == ST_HOLD) begin
      boot_mode_o <= boot_s2_q;
    end
  end

  // PLL multiplier: straps at start, software only once the lock wait is done
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_mult_o <= MULT_8;
    end else if (capture) begin
      pll_mult_o <= strap_mult;
    end else if (reg_we_i && reg_addr_i == PMC_ADDR && locked_q) begin
      pll_mult_o <= reg_wdata_i[MULT_LSB +: MULT_W];
    end
  end

  // PLL divider: straps leave it alone, software only once the lock wait is done
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_div_o <= DIV_RST;
    end else if (reg_we_i && reg_addr_i == PMC_ADDR && locked_q) begin
      pll_div_o <= reg_wdata_i[DIV_LSB +: DIV_W];
    end
  end

  // Pin mode; software may set or clear it at any time
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_input_q <= 1'b0;
    end else if (reg_we_i && reg_addr_i == RRC_ADDR) begin
      pin_input_q <= reg_wdata_i[RRC_INPUT_BIT];
    end
  end

  // Dual pin level: low until execution starts
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_output_n_o <= 1'b0;
    end else begin
      reset_output_n_o <= (state_d == ST_RUN);
    end
  end

  // Dual pin enable: driven unless made an input; kept driven through
  // the lock wait, where a running reset means nothing
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_output_oe_o <= 1'b1;
    end else begin
      reset_output_oe_o <= !pin_input_q || (state_d == ST_LOCK);
    end
  end

  // Settle count after the enable drops; a pin driven low through the
  // lock wait would otherwise read as a running reset at once
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= '0;
    end else if (reset_output_oe_o) begin
      settle_q <= '0;
    end else if (settle_q != 2'(SYNC_STAGES)) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Core hold and start pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      core_start_o <= 1'b0;
    end else begin
      core_reset_o <= (state_d != ST_RUN);
      core_start_o <= (state_d == ST_RUN) && (state_q != ST_RUN);
    end
  end

  // Fetch address handed to the core at every start
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_pc_o <= RESET_VECTOR;
    end else begin
      core_pc_o <= RESET_VECTOR;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_d = '0;
    if (reg_addr_i == PMC_ADDR) begin
      rd_d[MULT_LSB +: MULT_W] = pll_mult_o;
      rd_d[DIV_LSB +: DIV_W] = pll_div_o;
    end else if (reg_addr_i == RRC_ADDR) begin
      rd_d[RRC_INPUT_BIT] = pin_input_q;
    end else if (reg_addr_i == STATUS_ADDR) begin
      rd_d[ST_RATIO_LSB +: RATIO_W] = ratio_q;
      rd_d[ST_RSVD_BIT] = rsvd_q;
      rd_d[ST_BOOT_LSB +: BOOT_W] = boot_mode_o;
      rd_d[ST_STATE_LSB +: 2] = state_q;
      rd_d[ST_PINMODE_BIT] = pin_input_q;
      rd_d[ST_LOCKED_BIT] = locked_q;
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_d;
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule // startup_ctrl

// ==== dv/startup_ctrl_sva.sv ====
// Checker for the start-up sequence seen at the controller ports
`timescale 1ns/100ps
module startup_ctrl_sva import startup_pkg::*; #(
  parameter int LOCK_CYCLES = 16,
  parameter logic [31:0] RESET_VECTOR = 32'h0
) (
  // Clock, reset and straps
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [RATIO_W-1:0] clk_ratio_i,
  input wire logic [BOOT_W-1:0] boot_cfg_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Outputs under watch
  input wire logic reset_output_n_o,
  input wire logic reset_output_oe_o,
  input wire logic core_reset_o,
  input wire logic core_start_o,
  input wire logic [31:0] core_pc_o,
  input wire logic [BOOT_W-1:0] boot_mode_o,
  input wire logic [MULT_W-1:0] pll_mult_o,
  input wire logic [DIV_W-1:0] pll_div_o
);
  logic [15:0] cnt_q;
  logic [MULT_W-1:0] mult_exp;
  // Edges since release; saturates so a long run never wraps
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) cnt_q <= 16'h0;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h1;
  end
  // Multiplier the straps call for, reserved code falls to 8
  assign mult_exp = (clk_ratio_i == RATIO_32) ? MULT_32 :
    (clk_ratio_i == RATIO_16) ? MULT_16 : MULT_8;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  reset_state_a: assert property ($fell(rst_i) |-> core_reset_o && !core_start_o
    && pll_div_o == DIV_RST && reg_rdata_o == 32'h0) else $error("state after reset");
  lock_hold_a: assert property ((cnt_q < LOCK_CYCLES) |-> core_reset_o
    && reset_output_oe_o && !reset_output_n_o) else $error("core left lock early");
  first_start_a: assert property ((cnt_q == LOCK_CYCLES) |-> core_start_o
    && !core_reset_o && reset_output_n_o) else $error("core start late");
  strap_value_a: assert property ((cnt_q == LOCK_CYCLES) |-> pll_mult_o == mult_exp
    && boot_mode_o == boot_cfg_i) else $error("strap value wrong");
  start_pulse_a: assert property (core_start_o |-> core_pc_o == RESET_VECTOR
    ##1 !core_start_o) else $error("start pulse or vector wrong");
  pin_drive_a: assert property (core_reset_o && reset_output_oe_o |->
    !reset_output_n_o) else $error("reset out released in reset");
  pll_write_a: assert property (reg_we_i && reg_addr_i == PMC_ADDR && !core_reset_o |=>
    pll_mult_o == 7'($past(reg_wdata_i))) else $error("multiplier write lost");
  pin_input_a: assert property (reg_we_i && reg_addr_i == RRC_ADDR && reg_wdata_i[0]
    && !core_reset_o |-> ##[1:3] !reset_output_oe_o) else $error("pin not input");
endmodule // startup_ctrl_sva

// ==== dv/board_model.sv ====
// Board side: strap levels and the pulled-up reset pin
`timescale 1ns/100ps
module board_model (
  // Bench controls
  input wire logic pull_low_i,
  input wire logic [1:0] ratio_sel_i,
  input wire logic [2:0] boot_sel_i,
  // Device side
  input wire logic pin_out_n_i,
  input wire logic pin_oe_i,
  output logic pin_level_o,
  output logic [1:0] clk_ratio_o,
  output logic [2:0] boot_cfg_o
);
  // Straps stay valid across every reset, never floating
  assign clk_ratio_o = ratio_sel_i;
  assign boot_cfg_o = boot_sel_i;
  // Device drive wins; else board pulls low or the pull-up holds high
  assign pin_level_o = pin_oe_i ? pin_out_n_i : !pull_low_i;
endmodule // board_model

// ==== dv/testbench.sv ====
// Self-checking bench for the start-up controller
`timescale 1ns/100ps
module testbench;
  import startup_pkg::*;
  localparam int LOCK = 16;
  localparam logic [6:0] MT [4] = '{MULT_8, MULT_32, MULT_16, MULT_8};
  logic clk, rst, we, re, pull, pin_n, ro_n, oe, crst, cst;
  logic [1:0] rs, cr, div;
  logic [2:0] bs, bc, bm;
  logic [7:0] addr;
  logic [31:0] wd, rdat, pc;
  logic [6:0] mult;
  int miscompares, samples_checked, n;
  startup_ctrl #(.LOCK_CYCLES(LOCK)) i_dut (.sys_clk_i(clk), .rst_i(rst),
    .clk_ratio_i(cr), .boot_cfg_i(bc), .running_reset_n_i(pin_n),
    .reset_output_n_o(ro_n), .reset_output_oe_o(oe), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat),
    .core_reset_o(crst), .core_start_o(cst), .core_pc_o(pc), .boot_mode_o(bm),
    .pll_mult_o(mult), .pll_div_o(div));
  board_model i_board (.pull_low_i(pull), .ratio_sel_i(rs), .boot_sel_i(bs),
    .pin_out_n_i(ro_n), .pin_oe_i(oe), .pin_level_o(pin_n), .clk_ratio_o(cr),
    .boot_cfg_o(bc));
  // Free-running input clock, never stopped
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", s, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(s, rdat, e);
  endtask
  // Reset held high by the bench for 12 edges, then count edges to the start pulse
  task boot_up(input logic [1:0] r, input logic [2:0] b);
    @(posedge clk);
    rst <= 1'b1;
    rs <= r;
    bs <= b;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (cst !== 1'b1 && n < 100);
    chk("lock wait", n, LOCK);
    chk("core run", crst, 1'b0);
    chk("pc", pc, RESET_VECTOR_DEF);
    chk("reset out", ro_n, 1'b1);
  endtask
  // Wait on the start pulse or the held core, bounded
  task wt(input logic want_start);
    for (n = 0; n < 20 && (want_start ? cst : crst) !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    {rst, we, re, pull, rs, bs, addr, wd} = {4'h8, 5'h0, 8'h0, 32'h0};
    miscompares = 0;
    samples_checked = 0;
    // Every strap code, the reserved one included
    for (int i = 0; i < 4; i++) begin
      boot_up(2'(i), 3'(i + 3));
      chk("mult", mult, MT[i]);
      chk("boot", bm, 32'(i + 3));
      rd(STATUS_ADDR, 32'h280 | ((i + 3) << 3) | ((i == 3) << 2) | i, "status");
    end
    rd(8'h10, 32'h0, "unmapped");
    wr(PMC_ADDR, 32'h10c);
    #1 chk("retune", {div, mult}, 9'h08c);
    rd(PMC_ADDR, 32'h10c, "pmc");
    wr(RRC_ADDR, 32'h1);
    rd(RRC_ADDR, 32'h1, "rrc");
    chk("oe", oe, 1'b0);
    @(posedge clk);
    pull <= 1'b1;
    bs <= 3'h5;
    wt(1'b0);
    chk("held", crst, 1'b1);
    @(posedge clk);
    pull <= 1'b0;
    wt(1'b1);
    chk("restart", cst, 1'b1);
    chk("reboot mode", bm, 32'h5);
    // Reset in mid-run must restore every default
    @(posedge clk);
    rst <= 1'b1;
    #1 chk("reset", {crst, oe, ro_n, div}, 5'h18);
    boot_up(RATIO_16, 3'h1);
    rd(RRC_ADDR, 32'h0, "rrc default");
    rd(PMC_ADDR, {22'h0, DIV_RST, 1'b0, MULT_16}, "pmc default");
    stop_test;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
endmodule // testbench
bind startup_ctrl startup_ctrl_sva #(.LOCK_CYCLES(LOCK_CYCLES),
  .RESET_VECTOR(RESET_VECTOR)) i_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .clk_ratio_i(clk_ratio_i), .boot_cfg_i(boot_cfg_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o),
  .reset_output_n_o(reset_output_n_o), .reset_output_oe_o(reset_output_oe_o),
  .core_reset_o(core_reset_o), .core_start_o(core_start_o), .core_pc_o(core_pc_o),
  .boot_mode_o(boot_mode_o), .pll_mult_o(pll_mult_o), .pll_div_o(pll_div_o));
